// >>> sim/dac_host_model.sv
/* serial master model: drives select/load, serial clock and data pins.
   assumes clk is the 10 mhz bench clock; one sck period is 8 clk cycles. */
`timescale 1ns/1ps
module dac_host_model (
   input  wire logic        clk,
   input  wire logic        sdo,
   output      logic        sck,
   output      logic        sdi,
   output      logic        select_load_n,
   output      logic [31:0] sdo_cap
);
   // idle pins
   initial begin
      sck = 1'b0;
      sdi = 1'b0;
      select_load_n = 1'b1;
      sdo_cap = '0;
   end

   // n bits msb first; sel low clocks with the device deselected
   task automatic xfer(input logic [63:0] w, input int n, input bit sel);
      select_load_n <= !sel;
      for (int i = n - 1; i >= 0; i--) begin
         sdi <= w[i];
         repeat (5) @(posedge clk);
         sdo_cap <= {sdo_cap[30:0], sdo};
         sck <= 1'b1;
         repeat (3) @(posedge clk);
         sck <= 1'b0;
      end
      sdi <= ~w[0];  // released line shows the inverse
      repeat (5) @(posedge clk);
      select_load_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : xfer
endmodule : dac_host_model

// >>> sim/octal_dac_serial_control_bench.sv
/* testbench of the octal dac control: frames through the host model.
   assumes a 10 mhz clk and an 800 ns serial clock from the host model. */
`timescale 1ns/1ps
module octal_dac_serial_control_bench
   import dac_ctrl_pkg::*;
;
   logic              clk;
   logic              rst;
   logic              async_clear_n;
   logic              low_supply;
   logic              sck;
   logic              sdi;
   logic              select_load_n;
   logic              sdo;
   logic [31:0]       sdo_cap;
   code_bank_t        input_code;
   code_bank_t        dac_code;
   code_bank_t        ei;
   code_bank_t        ed;
   logic [NUM_CH-1:0] power_down;
   logic [NUM_CH-1:0] out_hiz;
   logic [NUM_CH-1:0] waking;
   logic [NUM_CH-1:0] epd;
   logic              bias_enable;
   logic              frame_done;
   int                err_total = 0;
   int                check_count = 0;
   int                fd_cnt = 0;

   octal_dac_serial_control u_octal_dac_serial_control (
      .clk(clk), .rst(rst), .sck(sck), .sdi(sdi), .select_load_n(select_load_n),
      .async_clear_n(async_clear_n), .low_supply(low_supply), .sdo(sdo),
      .input_code(input_code), .dac_code(dac_code), .power_down(power_down),
      .out_hiz(out_hiz), .waking(waking), .bias_enable(bias_enable),
      .frame_done(frame_done)
   );
   dac_host_model u_dac_host_model (
      .clk(clk), .sdo(sdo), .sck(sck), .sdi(sdi),
      .select_load_n(select_load_n), .sdo_cap(sdo_cap)
   );

   // clock and frame pulse count
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) if (frame_done === 1'b1) fd_cnt <= fd_cnt + 1;

   ////////////////////////////////////////////////////////////////////
   task automatic check_value(input string nm, input logic [127:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check_value

   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   // one frame, then compare the frame pulse count and the code, power and bias registers against the expected state
   task automatic frame(input logic [63:0] w, input int n, input bit sel, input int fd);
      int fd0;
      fd0 = fd_cnt;
      u_dac_host_model.xfer(w, n, sel);
      check_value("frame_done", 128'(fd_cnt - fd0), 128'(fd));
      check_value("input_code", input_code, ei);
      check_value("dac_code", dac_code, ed);
      check_value("power_down", {out_hiz, power_down}, {epd, epd});
      check_value("bias_enable", bias_enable, 128'(epd != MASK_ALL));
   endtask : frame

   // main sequence
   initial begin
      rst = 1'b1;
      async_clear_n = 1'b1;
      low_supply = 1'b0;
      ei = '0;
      ed = '0;
      epd = MASK_NONE;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      frame({CMD_NOP, ADDR_ALL, 16'h0000}, 24, 1, 1);
      ei[2] = 16'h1234;
      frame({CMD_WRITE, 4'h2, 16'h1234}, 24, 1, 1);
      ed[2] = 16'h1234;
      frame({CMD_UPDATE, 4'h2, 16'h0000}, 24, 1, 1);
      ei[7] = 16'hbeef;
      ed[7] = 16'hbeef;
      frame({8'ha5, CMD_WRITE_UPDATE, ADDR_LAST_CH, 16'hbeef}, 32, 1, 1);
      ei[0] = 16'h0f0f;
      ed = ei;
      frame({CMD_WRITE_UPD_ALL, 4'h0, 16'h0f0f}, 24, 1, 1);
      frame({CMD_WRITE, 4'h3, 16'h2222}, 20, 1, 0);
      frame({CMD_WRITE, 4'h3, 16'h3333}, 24, 0, 0);
      epd = 8'h01;
      frame({CMD_POWER_DOWN, 4'h0, 16'hffff}, 24, 1, 1);
      epd = MASK_NONE;
      ed[0] = ei[0];
      frame({CMD_UPDATE, 4'h0, 16'h0000}, 24, 1, 1);
      check_value("waking one", waking, 8'h01);
      repeat (40) @(posedge clk);
      check_value("waking short", waking, 8'h01);
      repeat (10) @(posedge clk);
      check_value("waking short over", waking, MASK_NONE);
      // all channels down, then woken at both supply levels
      for (int ls = 0; ls < 2; ls++) begin
         low_supply <= ls[0];
         epd = MASK_ALL;
         frame({CMD_POWER_DOWN, ADDR_ALL, 16'h0000}, 24, 1, 1);
         epd = MASK_NONE;
         ei = {8{16'h5555}};
         ed = ei;
         frame({CMD_WRITE_UPDATE, ADDR_ALL, 16'h5555}, 24, 1, 1);
         repeat (ls ? 280 : 100) @(posedge clk);
         check_value("waking long", waking, MASK_ALL);
         repeat (30) @(posedge clk);
         check_value("waking over", waking, MASK_NONE);
      end
      async_clear_n <= 1'b0;
      repeat (10) @(posedge clk);
      async_clear_n <= 1'b1;
      ei = '0;
      ed = '0;
      frame({CMD_NOP, ADDR_ALL, 16'h0000}, 24, 1, 1);
      frame({32'hc0de_1234, 8'h00, CMD_NOP, ADDR_ALL, 16'h0000}, 64, 1, 1);
      check_value("daisy out", sdo_cap, 32'hc0de_1234);
      report_and_stop();
   end

   // watchdog well beyond the expected run of about 0.4 ms
   initial begin
      #2_000_000;
      err_total++;
      report_and_stop();
   end
endmodule : octal_dac_serial_control_bench

// >>> sim/octal_dac_serial_control_chk.sv
/* checker: port-level properties of the octal dac control.
   assumes the single clk domain and the pin timing of the host model. */
`timescale 1ns/1ps
module dac_ctrl_chk
   import dac_ctrl_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              sck,
   input wire logic              select_load_n,
   input wire logic              async_clear_n,
   input wire logic              sdo,
   input wire code_bank_t        input_code,
   input wire code_bank_t        dac_code,
   input wire logic [NUM_CH-1:0] power_down,
   input wire logic [NUM_CH-1:0] out_hiz,
   input wire logic [NUM_CH-1:0] waking,
   input wire logic              bias_enable,
   input wire logic              frame_done
);
   logic [8:0] wk_cnt_r;

   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   // length of the current wake pulse of channel a
   always_ff @(posedge clk or posedge rst) begin
      if (rst) wk_cnt_r <= '0;
      else if (waking[0]) wk_cnt_r <= wk_cnt_r + 9'h001;
      else wk_cnt_r <= '0;
   end

   ////////////////////////////////////////////////////////////////////
   property p_hiz; out_hiz == power_down; endproperty
   a_hiz: assert property (p_hiz) else $error("hiz differs from power down");
   property p_bias; bias_enable == (power_down != MASK_ALL); endproperty
   a_bias: assert property (p_bias) else $error("bias enable wrong");
   property p_dac_src; $changed(dac_code) |-> frame_done || dac_code == '0; endproperty
   a_dac_src: assert property (p_dac_src) else $error("dac code moved alone");
   property p_pd_src; $changed(power_down) |-> frame_done; endproperty
   a_pd_src: assert property (p_pd_src) else $error("power state moved alone");
   property p_pd_keep;
      |(power_down & ~$past(power_down)) |-> $stable(input_code) && $stable(dac_code);
   endproperty
   a_pd_keep: assert property (p_pd_keep) else $error("power down moved codes");
   property p_wake; ($past(power_down) & ~power_down & ~waking) == MASK_NONE; endproperty
   a_wake: assert property (p_wake) else $error("wake missing on power up");
   property p_wake_len;
      $fell(waking[0]) |-> wk_cnt_r inside {9'h032, 9'h078, 9'h12c};
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake length wrong");
   property p_clear; !async_clear_n [*5] |-> dac_code == '0 && input_code == '0; endproperty
   a_clear: assert property (p_clear) else $error("clear left codes");
   property p_sdo; $changed(sdo) |-> !sck && !select_load_n; endproperty
   a_sdo: assert property (p_sdo) else $error("sdo moved off a falling edge");
   property p_done; frame_done |-> select_load_n ##1 !frame_done; endproperty
   a_done: assert property (p_done) else $error("frame done misplaced");

   // main scenarios reached
   c_frame: cover property (frame_done);
   c_wake: cover property ($fell(waking[0]));
   c_all_down: cover property (!bias_enable);
endmodule : dac_ctrl_chk

bind octal_dac_serial_control dac_ctrl_chk u_dac_ctrl_chk (
   .clk(clk), .rst(rst), .sck(sck), .select_load_n(select_load_n),
   .async_clear_n(async_clear_n), .sdo(sdo), .input_code(input_code),
   .dac_code(dac_code), .power_down(power_down), .out_hiz(out_hiz),
   .waking(waking), .bias_enable(bias_enable), .frame_done(frame_done)
);

// >>> verilog/dac_ctrl_pkg.sv
/*
 * shared constants and types of the octal dac serial control block:
 * frame layout, command and address codes, wake delays and cycle counts.
 * assumes a single 10 mhz system clock; all serial pins are sampled by it.
 */
package dac_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // sizes
   localparam int NUM_CH       = 8;
   localparam int CODE_W       = 16;
   localparam int FIELD_W      = 4;
   localparam int SHIFT_LEN    = 32;
   localparam int FRAME_MIN    = 24;
   localparam int BITCNT_W     = 6;
   localparam int WAKE_W       = 9;

   ////////////////////////////////////////////////////////////////////////////
   // command and address codes
   localparam logic [3:0] CMD_WRITE        = 4'h0;
   localparam logic [3:0] CMD_UPDATE       = 4'h1;
   localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
   localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
   localparam logic [3:0] CMD_POWER_DOWN   = 4'h4;
   localparam logic [3:0] CMD_NOP          = 4'hf;
   localparam logic [3:0] ADDR_ALL         = 4'hf;
   localparam logic [3:0] ADDR_LAST_CH     = 4'h7;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [CODE_W-1:0]  CODE_ZERO  = 16'h0000;
   localparam logic [SHIFT_LEN-1:0] SHIFT_ZERO = 32'h0000_0000;
   localparam logic [NUM_CH-1:0]  MASK_NONE  = 8'h00;
   localparam logic [NUM_CH-1:0]  MASK_ALL   = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // timing: wake delays in ns, cycle counts rounded up
   localparam int CLK_PERIOD_NS  = 100;
   localparam int WAKE_PART_NS   = 5000;
   localparam int WAKE_ALL_5V_NS = 12000;
   localparam int WAKE_ALL_3V_NS = 30000;
   localparam logic [WAKE_W-1:0] WAKE_PART_CYC =
      WAKE_W'((WAKE_PART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [WAKE_W-1:0] WAKE_ALL_5V_CYC =
      WAKE_W'((WAKE_ALL_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [WAKE_W-1:0] WAKE_ALL_3V_CYC =
      WAKE_W'((WAKE_ALL_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic [FIELD_W-1:0] command_field;
      logic [FIELD_W-1:0] channel_address_field;
      logic [CODE_W-1:0]  data_word;
   } frame_t;

   typedef logic [NUM_CH-1:0][CODE_W-1:0] code_bank_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_EXEC  = 2'b11
   } frame_state_t;

   // asynchronous pins, sampled together by one synchroniser
   typedef struct packed {
      logic sel_n;
      logic clr_n;
      logic sck;
      logic sdi;
   } pin_group_t;

   // idle pin levels: deselected, clear released, clock and data low
   localparam pin_group_t PIN_IDLE = '{sel_n: 1'b1, clr_n: 1'b1, sck: 1'b0, sdi: 1'b0};

endpackage : dac_ctrl_pkg

// >>> verilog/octal_dac_serial_control.sv
/*
 * digital control of an octal double-buffered dac: serial frame capture,
 * command decode, input and dac registers, power-down and wake timing.
 * assumes sck, sdi, select_load_n and async_clear_n come from pins and are
 * far slower than clk; low_supply tells the 3 v wake delay apart.
 * hazards: every pin is seen two clk cycles late, so sck must stay high and
 * low for at least two clk cycles each; frames shorter than 24 bits are
 * dropped; a low clear beats any write or code update in the same cycle;
 * power-down state and the shift path survive a clear.
 */
`timescale 1ns/1ps
module octal_dac_serial_control
   import dac_ctrl_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              sck,
   input  wire logic              sdi,
   input  wire logic              select_load_n,
   input  wire logic              async_clear_n,
   input  wire logic              low_supply,
   output      logic              sdo,
   output      code_bank_t        input_code,
   output      code_bank_t        dac_code,
   output      logic [NUM_CH-1:0] power_down,
   output      logic [NUM_CH-1:0] out_hiz,
   output      logic [NUM_CH-1:0] waking,
   output      logic              bias_enable,
   output      logic              frame_done
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   pin_group_t pins_raw;
   pin_group_t pins_s;
   logic       sck_s;
   logic       sdi_s;
   logic       sel_n_s;
   logic       clr_n_s;

   // gather the asynchronous pins into one synchroniser group
   assign pins_raw = '{
      sel_n: select_load_n,
      clr_n: async_clear_n,
      sck:   sck,
      sdi:   sdi
   };

   // resets to the idle levels so no false edge follows reset
   pin_sync #(
      .WIDTH   ($bits(pin_group_t)),
      .RST_VAL (PIN_IDLE)
   ) u_pin_sync (
      .clk (clk),
      .rst (rst),
      .d   (pins_raw),
      .q   (pins_s)
   );

   // synchronised pins, the only copies read by the logic
   assign sel_n_s = pins_s.sel_n;
   assign clr_n_s = pins_s.clr_n;
   assign sck_s   = pins_s.sck;
   assign sdi_s   = pins_s.sdi;

   ////////////////////////////////////////////////////////////////////////////
   // edge detection on synchronised pins

   logic sck_d_r;
   logic sel_n_d_r;
   logic sck_rise;
   logic sck_fall;
   logic sel_rise;

   // delayed copies for edge detection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_d_r   <= 1'b0;
         sel_n_d_r <= 1'b1;
      end else begin
         sck_d_r   <= sck_s;
         sel_n_d_r <= sel_n_s;
      end
   end

   assign sck_rise = sck_s & ~sck_d_r;
   assign sck_fall = ~sck_s & sck_d_r;
   assign sel_rise = sel_n_s & ~sel_n_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // frame state machine

   frame_state_t state_r;
   frame_state_t state_nxt;

   // idle until select low, shift, then one execute cycle
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (!sel_n_s) begin
               state_nxt = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (sel_rise) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shift register and bit counter

   logic [SHIFT_LEN-1:0] shift_r;
   logic [BITCNT_W-1:0]  bitcnt_r;
   logic                 shift_en;

   assign shift_en = ~sel_n_s & sck_rise;

   // 32-stage shift path, msb first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_r <= SHIFT_ZERO;
      end else if (shift_en) begin
         shift_r <= {shift_r[SHIFT_LEN-2:0], sdi_s};
      end
   end

   // counts bits of this frame, saturating at the minimum frame length
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bitcnt_r <= '0;
      end else if (state_r == ST_IDLE) begin
         bitcnt_r <= '0;
      end else if (shift_en && bitcnt_r != BITCNT_W'(FRAME_MIN)) begin
         bitcnt_r <= bitcnt_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial output for daisy chaining

   // oldest stage goes out on the falling edge after its 32nd rise,
   // counting the rise that shifted it in; a downstream device then
   // takes it on the next rise, so a chain acts as one long register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sdo <= 1'b0;
      end else if (~sel_n_s & sck_fall) begin
         sdo <= shift_r[SHIFT_LEN-1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame decode

   frame_t            frame;
   logic              exec;
   logic              frame_len_ok;
   logic [NUM_CH-1:0] sel_mask;
   logic [NUM_CH-1:0] wr_mask;
   logic [NUM_CH-1:0] upd_mask;
   logic [NUM_CH-1:0] pd_mask;

   // last 24 bits whatever the frame length; leading bits drop off the top
   assign frame = frame_t'(shift_r[FRAME_MIN-1:0]);

   // a frame counts once it has reached the minimum length
   assign frame_len_ok = (bitcnt_r == BITCNT_W'(FRAME_MIN));

   // short frames are dropped
   assign exec = (state_r == ST_EXEC) && frame_len_ok;

   // address to channel mask
   always_comb begin
      sel_mask = MASK_NONE;
      if (frame.channel_address_field == ADDR_ALL) begin
         sel_mask = MASK_ALL;
      end else if (frame.channel_address_field <= ADDR_LAST_CH) begin
         sel_mask[frame.channel_address_field[2:0]] = 1'b1;
      end
   end

   // command to write, update and power-down masks
   always_comb begin
      wr_mask  = MASK_NONE;
      upd_mask = MASK_NONE;
      pd_mask  = MASK_NONE;
      if (exec) begin
         case (frame.command_field)
            CMD_WRITE: begin
               wr_mask = sel_mask;
            end
            CMD_UPDATE: begin
               upd_mask = sel_mask;
            end
            CMD_WRITE_UPD_ALL: begin
               wr_mask  = sel_mask;
               upd_mask = MASK_ALL;
            end
            CMD_WRITE_UPDATE: begin
               wr_mask  = sel_mask;
               upd_mask = sel_mask;
            end
            CMD_POWER_DOWN: begin
               pd_mask = sel_mask;
            end
            default: begin
               wr_mask = MASK_NONE;  // nop and reserved codes
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clear handling

   logic clear;

   assign clear = ~clr_n_s;

   ////////////////////////////////////////////////////////////////////////////
   // per-channel registers, power state and wake timers

   logic              all_down;
   logic [NUM_CH-1:0] pd_nxt;
   logic [WAKE_W-1:0] wake_len;

   assign all_down = &power_down;
   assign pd_nxt   = (power_down | pd_mask) & ~upd_mask;

   // wake delay depends on whether the bias had been shut down
   always_comb begin
      if (!all_down) begin
         wake_len = WAKE_PART_CYC;
      end else if (low_supply) begin
         wake_len = WAKE_ALL_3V_CYC;
      end else begin
         wake_len = WAKE_ALL_5V_CYC;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         logic [CODE_W-1:0] in_nxt;
         logic [WAKE_W-1:0] wake_cnt_r;
         logic              wake_go;

         // a write to this channel in this frame also reaches an update of it
         assign in_nxt = wr_mask[ch] ? frame.data_word : input_code[ch];

         // only a powered-down channel pays the wake delay
         assign wake_go = upd_mask[ch] & power_down[ch];

         // input register; power-down leaves it alone
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               input_code[ch] <= CODE_ZERO;
            end else if (clear) begin
               input_code[ch] <= CODE_ZERO;
            end else if (wr_mask[ch]) begin
               input_code[ch] <= frame.data_word;
            end
         end

         // dac register, the active code
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               dac_code[ch] <= CODE_ZERO;
            end else if (clear) begin
               dac_code[ch] <= CODE_ZERO;
            end else if (upd_mask[ch]) begin
               dac_code[ch] <= in_nxt;
            end
         end

         // power-down state and high impedance request
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               power_down[ch] <= 1'b0;
               out_hiz[ch]    <= 1'b0;
            end else begin
               power_down[ch] <= pd_nxt[ch];
               out_hiz[ch]    <= pd_nxt[ch];
            end
         end

         // wake timer, started by an update of a powered-down channel
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               wake_cnt_r <= '0;
               waking[ch] <= 1'b0;
            end else if (wake_go) begin
               wake_cnt_r <= wake_len;
               waking[ch] <= 1'b1;
            end else if (wake_cnt_r != '0) begin
               wake_cnt_r <= wake_cnt_r - 1'b1;
               waking[ch] <= (wake_cnt_r != WAKE_W'(1));
            end else begin
               waking[ch] <= 1'b0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // shared bias and frame completion

   // bias off only while every channel is powered down
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bias_enable <= 1'b1;
      end else begin
         bias_enable <= ~&pd_nxt;
      end
   end

   // one-cycle pulse when a complete frame was executed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frame_done <= 1'b0;
      end else begin
         frame_done <= exec;
      end
   end

endmodule : octal_dac_serial_control

// >>> verilog/pin_sync.sv
/*
 * two flip-flop synchroniser for a group of pin inputs.
 * assumes the pins are asynchronous to clk; rst_val gives the idle level.
 */
`timescale 1ns/1ps
module pin_sync #(
   parameter int              WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output      logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;

   // first stage, read only by the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= RST_VAL;
      end else begin
         meta_r <= d;
      end
   end

   // second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= RST_VAL;
      end else begin
         q <= meta_r;
      end
   end

endmodule : pin_sync
